// ==== hw/bmsp_pkg.sv ====
package bmsp_pkg;

    // Register byte offsets
    localparam logic [7:0] BMSP_CTRL_OFF = 8'h00;
    localparam logic [7:0] BMSP_STAT_OFF = 8'h04;
    localparam logic [7:0] BMSP_SPORT_OFF = 8'h08;
    localparam logic [7:0] BMSP_CLK_OFF = 8'h0c;

    // Control, serial port and clock register fields
    localparam int STAT_FN_LSB = 0;
    localparam int STAT_GPO_BIT = 2;
    localparam int SPORT_ASYNC_BIT = 0;
    localparam int SPORT_CLK_OE_BIT = 1;
    localparam int SPORT_CLK_OUT_BIT = 2;
    localparam int CLK_DBL_BIT = 0;
    localparam int CLK_SPR_LSB = 1;

    // Reset values
    localparam logic [1:0] STAT_FN_RST = 2'h0;
    localparam logic DBL_RST = 1'b1;
    localparam logic [1:0] SPR_RST = 2'h1;

    // Clock figures, kHz
    localparam int RESONATOR_KHZ = 22120;
    localparam int CORE_DBL_KHZ = 44200;

    // Spreader settings
    localparam logic [1:0] SPR_OFF = 2'h0;
    localparam logic [1:0] SPR_NORMAL = 2'h1;
    localparam logic [1:0] SPR_STRONG = 2'h2;

    // Async boot rate
    localparam int BOOT_BAUD = 2400;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        BOOT_ADDR_ZERO,
        BOOT_SLAVE_PORT,
        BOOT_SERIAL_CLOCKED,
        BOOT_SERIAL_ASYNC
    } bmsp_boot_t;

    typedef enum logic [1:0] {
        STAT_FN_FETCH,
        STAT_FN_IACK,
        STAT_FN_GPO
    } bmsp_stat_fn_t;

    localparam logic [15:0] BOOT_VECTOR = 16'h0000;

endpackage : bmsp_pkg

// ==== hw/bmsp_sync.sv ====
module bmsp_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic d,
    output logic q
);
    logic s1_r;
    logic s1_nxt;
    logic q_nxt;

    always_comb begin
        s1_nxt = d;
        q_nxt = s1_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 1'b0;
            q <= 1'b0;
        end else begin
            s1_r <= s1_nxt;
            q <= q_nxt;
        end
    end
endmodule : bmsp_sync

// ==== hw/bmsp_top.sv ====
// Functional notes
// - After every reset the boot select pins decide cold boot or execution from 0x0000.
// - Pins 00 run at zero, 01 slave port, 10 clocked serial, 11 async serial at 2400 bps.
// - The attached programming connector pulls both pins high, giving Program Mode.
// - With no connector the pins sit low and the device enters Run Mode.
// - The application runs in either mode, but download and debug only in Program Mode.
// - In fetch mode the status output goes low during the first fetch after reset.
// - In interrupt mode the status output goes low through each acknowledge cycle.
// - In general-purpose mode software drives the status output directly.
// - The external reset input resets the processor and all onboard peripherals.
// - The serial port runs clocked, or async with its clock line as a general I/O.
// - A running application may read the boot pins and drive the status pin.
// - The core clock is doubled from the resonator by default; a setting disables it.
// - The spreader takes 0 off, 1 normal by default, 2 strong (not advised here).
module bmsp_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_reset_n,
    input wire logic boot_select_low_pin,
    input wire logic boot_select_high_pin,
    input wire logic first_fetch,
    input wire logic iack_cycle,
    input wire logic dbg_req,
    input wire logic sport_clk_in,
    output logic status_pin,
    output logic sport_clk_out,
    output logic sport_clk_oe,
    output logic sport_async,
    output logic periph_reset_n,
    output logic program_mode,
    output logic dbg_enable,
    output logic [1:0] boot_mode,
    output logic clk_doubler_en,
    output logic [1:0] spreader_sel,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic ext_rst_s;
    logic bsel_lo_s;
    logic bsel_hi_s;
    logic sclk_s;

    bmsp_sync u_sync_rst (.aclk(aclk), .aresetn(aresetn), .d(ext_reset_n), .q(ext_rst_s));
    bmsp_sync u_sync_lo (.aclk(aclk), .aresetn(aresetn), .d(boot_select_low_pin),
        .q(bsel_lo_s));
    bmsp_sync u_sync_hi (.aclk(aclk), .aresetn(aresetn), .d(boot_select_high_pin),
        .q(bsel_hi_s));
    bmsp_sync u_sync_sclk (.aclk(aclk), .aresetn(aresetn), .d(sport_clk_in), .q(sclk_s));

    function automatic logic [1:0] boot_decode(input logic lo, input logic hi);
        boot_decode = {lo, hi};
    endfunction : boot_decode

    ////////////////////////////////////////////////////////////////////////////
    // Reset and boot capture
    // Synchroniser output is 0 under aresetn, so wait two cycles before trusting it.
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;
    logic sampled_r;
    logic sampled_nxt;
    logic [1:0] boot_r;
    logic [1:0] boot_nxt;
    logic fetch_seen_r;
    logic fetch_seen_nxt;
    logic core_rst;

    assign core_rst = !aresetn || (settle_r == 2'h2 && !ext_rst_s);

    always_comb begin
        settle_nxt = settle_r;
        sampled_nxt = sampled_r;
        boot_nxt = boot_r;
        fetch_seen_nxt = fetch_seen_r;
        if (settle_r != 2'h2) begin
            settle_nxt = settle_r + 2'h1;
        end else if (!ext_rst_s) begin
            sampled_nxt = 1'b0;
            fetch_seen_nxt = 1'b0;
        end else begin
            if (!sampled_r) begin
                sampled_nxt = 1'b1;
                boot_nxt = boot_decode(bsel_lo_s, bsel_hi_s);
            end
            if (sampled_r && first_fetch) begin
                fetch_seen_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_r <= 2'h0;
            sampled_r <= 1'b0;
            boot_r <= 2'h0;
            fetch_seen_r <= 1'b0;
        end else begin
            settle_r <= settle_nxt;
            sampled_r <= sampled_nxt;
            boot_r <= boot_nxt;
            fetch_seen_r <= fetch_seen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [1:0] stat_fn_r;
    logic [1:0] stat_fn_nxt;
    logic gpo_r;
    logic gpo_nxt;
    logic sp_async_r;
    logic sp_async_nxt;
    logic sp_oe_r;
    logic sp_oe_nxt;
    logic sp_out_r;
    logic sp_out_nxt;
    logic dbl_r;
    logic dbl_nxt;
    logic [1:0] spr_r;
    logic [1:0] spr_nxt;

    logic aw_held_r;
    logic aw_held_nxt;
    logic [7:0] aw_addr_r;
    logic [7:0] aw_addr_nxt;
    logic w_held_r;
    logic w_held_nxt;
    logic [31:0] w_data_r;
    logic [31:0] w_data_nxt;
    logic [3:0] w_strb_r;
    logic [3:0] w_strb_nxt;
    logic bvalid_nxt;
    logic [1:0] bresp_nxt;
    logic rvalid_nxt;
    logic [1:0] rresp_nxt;
    logic [31:0] rdata_nxt;
    logic awready_nxt;
    logic wready_nxt;
    logic arready_nxt;

    always_comb begin
        stat_fn_nxt = stat_fn_r;
        gpo_nxt = gpo_r;
        sp_async_nxt = sp_async_r;
        sp_oe_nxt = sp_oe_r;
        sp_out_nxt = sp_out_r;
        dbl_nxt = dbl_r;
        spr_nxt = spr_r;
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = s_axi_bvalid;
        bresp_nxt = s_axi_bresp;
        rvalid_nxt = s_axi_rvalid;
        rresp_nxt = s_axi_rresp;
        rdata_nxt = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_held_r && w_held_r && !s_axi_bvalid) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = bmsp_pkg::RESP_OKAY;
            if (w_strb_r[0]) begin
                case (aw_addr_r)
                    bmsp_pkg::BMSP_CTRL_OFF: begin
                        stat_fn_nxt = w_data_r[bmsp_pkg::STAT_FN_LSB +: 2];
                        gpo_nxt = w_data_r[bmsp_pkg::STAT_GPO_BIT];
                    end
                    bmsp_pkg::BMSP_SPORT_OFF: begin
                        sp_async_nxt = w_data_r[bmsp_pkg::SPORT_ASYNC_BIT];
                        sp_oe_nxt = w_data_r[bmsp_pkg::SPORT_CLK_OE_BIT];
                        sp_out_nxt = w_data_r[bmsp_pkg::SPORT_CLK_OUT_BIT];
                    end
                    bmsp_pkg::BMSP_CLK_OFF: begin
                        dbl_nxt = w_data_r[bmsp_pkg::CLK_DBL_BIT];
                        spr_nxt = w_data_r[bmsp_pkg::CLK_SPR_LSB +: 2];
                    end
                    bmsp_pkg::BMSP_STAT_OFF: begin
                    end
                    default: bresp_nxt = bmsp_pkg::RESP_SLVERR;
                endcase
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = bmsp_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            case (s_axi_araddr)
                bmsp_pkg::BMSP_CTRL_OFF:
                    rdata_nxt = {29'h0, gpo_r, stat_fn_r};
                bmsp_pkg::BMSP_STAT_OFF:
                    rdata_nxt = {24'h0, sclk_s, bsel_hi_s, bsel_lo_s, fetch_seen_r,
                        program_mode, sampled_r, boot_r};
                bmsp_pkg::BMSP_SPORT_OFF:
                    rdata_nxt = {29'h0, sp_out_r, sp_oe_r, sp_async_r};
                bmsp_pkg::BMSP_CLK_OFF:
                    rdata_nxt = {29'h0, spr_r, dbl_r};
                default: rresp_nxt = bmsp_pkg::RESP_SLVERR;
            endcase
        end
        awready_nxt = !aw_held_nxt;
        wready_nxt = !w_held_nxt;
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_fn_r <= bmsp_pkg::STAT_FN_RST;
            gpo_r <= 1'b1;
            sp_async_r <= 1'b0;
            sp_oe_r <= 1'b0;
            sp_out_r <= 1'b0;
            dbl_r <= bmsp_pkg::DBL_RST;
            spr_r <= bmsp_pkg::SPR_RST;
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            stat_fn_r <= stat_fn_nxt;
            gpo_r <= gpo_nxt;
            sp_async_r <= sp_async_nxt;
            sp_oe_r <= sp_oe_nxt;
            sp_out_r <= sp_out_nxt;
            dbl_r <= dbl_nxt;
            spr_r <= spr_nxt;
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rresp <= rresp_nxt;
            s_axi_rdata <= rdata_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready <= wready_nxt;
            s_axi_arready <= arready_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin outputs
    logic status_nxt;
    logic pm_nxt;

    always_comb begin
        pm_nxt = sampled_r && (boot_r == bmsp_pkg::BOOT_SERIAL_ASYNC);
        case (stat_fn_r)
            bmsp_pkg::STAT_FN_FETCH: status_nxt = !(sampled_r && first_fetch && !fetch_seen_r);
            bmsp_pkg::STAT_FN_IACK: status_nxt = !iack_cycle;
            bmsp_pkg::STAT_FN_GPO: status_nxt = gpo_r;
            default: status_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (core_rst) begin
            status_pin <= 1'b1;
            program_mode <= 1'b0;
            dbg_enable <= 1'b0;
            boot_mode <= 2'h0;
            periph_reset_n <= 1'b0;
            sport_clk_out <= 1'b0;
            sport_clk_oe <= 1'b0;
            sport_async <= 1'b0;
            clk_doubler_en <= bmsp_pkg::DBL_RST;
            spreader_sel <= bmsp_pkg::SPR_RST;
        end else begin
            status_pin <= status_nxt;
            program_mode <= pm_nxt;
            dbg_enable <= pm_nxt && dbg_req;
            boot_mode <= boot_r;
            periph_reset_n <= sampled_r;
            // Clock line is GPIO only in async mode
            sport_async <= sp_async_r;
            sport_clk_oe <= sp_async_r && sp_oe_r;
            sport_clk_out <= sp_async_r && sp_out_r;
            clk_doubler_en <= dbl_r;
            // Strong kept as written, code 3 treated as normal
            spreader_sel <= (spr_r == 2'h3) ? bmsp_pkg::SPR_NORMAL : spr_r;
        end
    end

endmodule : bmsp_top

// ==== verification/bmsp_checker.sv ====
module bmsp_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_reset_n,
    input wire logic dbg_req,
    input wire logic program_mode,
    input wire logic dbg_enable,
    input wire logic [1:0] boot_mode,
    input wire logic periph_reset_n,
    input wire logic sport_clk_oe,
    input wire logic sport_async,
    input wire logic [1:0] spreader_sel,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Enable and mode leave the same register stage, so they are compared in one cycle
    dbg_gate_a: assert property (dbg_enable |-> program_mode && $past(dbg_req))
        else $error("debug enabled outside program mode");
    mode_match_a: assert property (periph_reset_n |-> program_mode == (boot_mode == 2'h3))
        else $error("program mode disagrees with boot pins");
    boot_hold_a: assert property (periph_reset_n && $past(periph_reset_n) |-> $stable(boot_mode))
        else $error("boot mode changed while running");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    spread_legal_a: assert property (spreader_sel != 2'h3)
        else $error("illegal spreader setting");
    clk_gpio_a: assert property (sport_clk_oe |-> sport_async)
        else $error("clock pin driven outside async mode");
    ext_reset_a: assert property ((!ext_reset_n) [*4] |-> !periph_reset_n)
        else $error("peripheral reset missing");
endmodule : bmsp_checker

bind bmsp_top bmsp_checker i_chk (.aclk, .aresetn, .ext_reset_n, .dbg_req, .program_mode,
    .dbg_enable, .boot_mode, .periph_reset_n, .sport_clk_oe, .sport_async, .spreader_sel,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);

// ==== verification/bmsp_host_model.sv ====
module bmsp_host_model (
    input wire logic attached,
    input wire logic [1:0] strap,
    input wire logic rst_req,
    input wire logic dbg_want,
    output logic boot_select_low_pin,
    output logic boot_select_high_pin,
    output logic ext_reset_n,
    output logic dbg_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cable pulls pins; board strap otherwise
    assign boot_select_low_pin = attached | strap[1];
    assign boot_select_high_pin = attached | strap[0];
    assign ext_reset_n = !rst_req;
    assign dbg_req = dbg_want;
endmodule : bmsp_host_model

// ==== verification/boot_mode_status_port_test.sv ====
module boot_mode_status_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic attached = 1'b0, rst_req = 1'b0, dbg_want = 1'b0;
    logic [1:0] strap = 2'h0;
    logic first_fetch = 1'b0, iack_cycle = 1'b0, sport_clk_in = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic boot_select_low_pin, boot_select_high_pin, ext_reset_n, dbg_req;
    logic status_pin, sport_clk_out, sport_clk_oe, sport_async, periph_reset_n;
    logic program_mode, dbg_enable, clk_doubler_en;
    logic [1:0] boot_mode, spreader_sel, s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_rdata, rd;
    logic [1:0] rs;
    int n_mismatch = 0;
    int comparisons = 0;

    always #5 aclk = ~aclk;

    bmsp_host_model i_host (.attached, .strap, .rst_req, .dbg_want, .boot_select_low_pin,
        .boot_select_high_pin, .ext_reset_n, .dbg_req);
    bmsp_top i_dut (.aclk, .aresetn, .ext_reset_n, .boot_select_low_pin, .boot_select_high_pin,
        .first_fetch, .iack_cycle, .dbg_req, .sport_clk_in, .status_pin, .sport_clk_out,
        .sport_clk_oe, .sport_async, .periph_reset_n, .program_mode, .dbg_enable, .boot_mode,
        .clk_doubler_en, .spreader_sel, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // No cycle count is assumed: only the watchdog ends a hung wait
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    task automatic do_reset(input logic att, input logic [1:0] st);
        attached <= att;
        strap <= st;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_boot;
        for (int i = 0; i < 4; i++) begin
            do_reset(i == 3, (i == 3) ? 2'h0 : i[1:0]);
            dbg_want <= 1'b1;
            repeat (3) @(posedge aclk);
            chk(boot_mode, i);
            chk(program_mode, i == 3);
            chk(dbg_enable, i == 3);
            dbg_want <= 1'b0;
            attached <= 1'b0;
            strap <= ~i[1:0];
            repeat (4) @(posedge aclk);
            chk(boot_mode, i);
            axi_rd(bmsp_pkg::BMSP_STAT_OFF);
            chk(rd[6:0], {~i[0], ~i[1], 1'b0, i == 3, 1'b1, i[1:0]});
        end
    endtask : t_boot

    task automatic t_status;
        for (int p = 0; p < 2; p++) begin
            first_fetch <= 1'b1;
            @(posedge aclk);
            first_fetch <= 1'b0;
            @(posedge aclk);
            chk(status_pin, p);
            @(posedge aclk);
            chk(status_pin, 1'b1);
        end
        axi_wr(bmsp_pkg::BMSP_CTRL_OFF, 32'h1, 4'hf);
        iack_cycle <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            @(posedge aclk);
            if (k == 2) iack_cycle <= 1'b0;
            if (k > 0) chk(status_pin, k == 4);
        end
        axi_wr(bmsp_pkg::BMSP_CTRL_OFF, 32'h2, 4'hf);
        chk(status_pin, 1'b0);
        axi_wr(bmsp_pkg::BMSP_CTRL_OFF, 32'h6, 4'hf);
        chk(status_pin, 1'b1);
        axi_rd(bmsp_pkg::BMSP_CTRL_OFF);
        chk(rd[2:0], 3'h6);
    endtask : t_status

    task automatic t_regs;
        axi_wr(bmsp_pkg::BMSP_SPORT_OFF, 32'h7, 4'hf);
        chk({sport_async, sport_clk_oe, sport_clk_out}, 3'h7);
        axi_wr(bmsp_pkg::BMSP_SPORT_OFF, 32'h1, 4'hf);
        chk({sport_async, sport_clk_oe, sport_clk_out}, 3'h4);
        // The pin needs both synchroniser stages before the read samples it
        sport_clk_in <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_rd(bmsp_pkg::BMSP_STAT_OFF);
        chk(rd[7], 1'b1);
        axi_rd(bmsp_pkg::BMSP_CLK_OFF);
        chk(rd[2:0], 3'h3);
        chk({clk_doubler_en, spreader_sel}, 3'h5);
        for (int s = 0; s < 4; s++) begin
            axi_wr(bmsp_pkg::BMSP_CLK_OFF, s << 1, 4'hf);
            chk({clk_doubler_en, spreader_sel}, (s == 3) ? 1 : s);
        end
        axi_rd(8'h10);
        chk(rs, bmsp_pkg::RESP_SLVERR);
        axi_wr(8'h10, 32'h1, 4'hf);
        chk(rs, bmsp_pkg::RESP_SLVERR);
        axi_wr(bmsp_pkg::BMSP_CLK_OFF, 32'h1, 4'h0);
        chk(rs, bmsp_pkg::RESP_OKAY);
        axi_rd(bmsp_pkg::BMSP_CLK_OFF);
        // Code 3 stays in the register and is folded to normal only at the pin
        chk(rd[2:0], 3'h6);
    endtask : t_regs

    task automatic t_ext;
        do_reset(1'b0, 2'h0);
        chk(program_mode, 1'b0);
        attached <= 1'b1;
        rst_req <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(periph_reset_n, 1'b0);
        rst_req <= 1'b0;
        repeat (8) @(posedge aclk);
        chk({periph_reset_n, program_mode}, 2'h3);
    endtask : t_ext

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        t_boot();
        do_reset(1'b1, 2'h0);
        t_status();
        t_regs();
        t_ext();
        summarize();
    end

    // A hang anywhere ends the run as a failure
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        summarize();
    end
endmodule : boot_mode_status_port_test
